// ### verilog/uedma_pkg.sv
// uedma_pkg: constants, register map and types of the endpoint dma
// request logic; assumes one 50 MHz clock and a plain register port.
// Contract
// - endpoint zero never raises external dma requests
// - three receive and three transmit request channels, endpoint selectable
// - receive channels for host in and device out, transmit otherwise; the code ignores the host bit, rx and tx channels are fixed
// - per-transfer mode interrupts only when the whole transfer finishes
// - per-packet mode requests only full packets, short packet interrupts
// - auto packet arm marks a full transmit packet ready by itself
// - auto packet release frees a drained receive packet by itself
// - per-transfer receive completes even on a short final packet
// - dma completion shares the usb interrupt, means fifo moved only
// - no status flag records that dma completion caused an interrupt
// - receive interrupt on short packet, error, transmit done, completion
// - transmit request stays up while fifo space remains and enabled; the code drops it after each burst until space falls
// - transceiver powered after reset, power-on restores it
// - controller does not operate while transceiver is powered down
`default_nettype none

package uedma_pkg;
   localparam int NUM_CH   = 3;
   localparam int EP_W     = 4;
   localparam int CNT_W    = 16;
   localparam int AW       = 4;
   // register offsets
   localparam logic [AW-1:0] REG_CTRL   = 4'h0;
   localparam logic [AW-1:0] REG_STATUS = 4'h1;
   localparam logic [AW-1:0] REG_MASK   = 4'h2;
   localparam logic [AW-1:0] REG_RXEP   = 4'h3;
   localparam logic [AW-1:0] REG_TXEP   = 4'h4;
   localparam logic [AW-1:0] REG_RXLEN  = 4'h5;
   localparam logic [AW-1:0] REG_TXLEN  = 4'h6;
   localparam logic [AW-1:0] REG_STATE  = 4'h7;
   // control bit positions
   localparam int CTRL_HOST    = 0;
   localparam int CTRL_PWRDN   = 1;
   localparam int CTRL_RXMODE  = 2;
   localparam int CTRL_TXMODE  = 3;
   localparam int CTRL_ARM     = 4;
   localparam int CTRL_RELEASE = 5;
   localparam int CTRL_RXEN    = 6;
   localparam int CTRL_TXEN    = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // status bit positions
   localparam int ST_RXDONE = 0;
   localparam int ST_RXSHRT = 1;
   localparam int ST_RXERR  = 2;
   localparam int ST_TXDONE = 3;
   localparam int ST_TXPKT  = 4;
   localparam int ST_W      = 5;
   localparam logic [EP_W-1:0] EP_CONTROL = 4'h0;

   typedef enum logic { per_transfer_request_mode,
                        per_packet_request_mode } uedma_mode_type;
   typedef enum { CH_IDLE, CH_REQ, CH_WAIT } uedma_ch_state_type;
endpackage : uedma_pkg

`default_nettype wire

// ### verilog/uedma_channel.sv
// uedma_channel: one request line toward the external dma controller;
// assumes burst_done is a one-cycle pulse from the fifo side.
`default_nettype none

module uedma_channel
   import uedma_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic arst_n,
   // condition and acknowledge
   input  wire logic allowed,
   input  wire logic cond,
   input  wire logic burst_done,
   // request
   output logic      req
);
   typedef struct packed {
      uedma_ch_state_type st;
      logic               req;
   } uedma_chs_type;

   uedma_chs_type r;
   uedma_chs_type next_r;

   // hold until burst moved, then wait for condition to fall
   always_comb
   begin
      next_r = r;
      case (r.st)
         CH_IDLE:
            if (allowed && cond)
            begin
               next_r.st  = CH_REQ;
               next_r.req = 1'b1;
            end
         CH_REQ:
            if (!allowed)
            begin
               next_r.st  = CH_IDLE;
               next_r.req = 1'b0;
            end
            else if (burst_done)
            begin
               next_r.st  = CH_WAIT;
               next_r.req = 1'b0;
            end
         CH_WAIT:
            if (!cond || !allowed)
               next_r.st = CH_IDLE;
         default:
         begin
            next_r.st  = CH_IDLE;
            next_r.req = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         r <= '{st: CH_IDLE, req: 1'b0};
      else
         r <= next_r;
   end

   assign req = r.req;
endmodule : uedma_channel

`default_nettype wire

// ### verilog/uedma_top.sv
// uedma_top: endpoint dma request logic with register port and interrupt;
// assumes fifo events from the packet engine are one-cycle pulses.
`default_nettype none

module uedma_top
   import uedma_pkg::*;
(
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    arst_n,
   // register port
   input  wire logic [AW-1:0]           reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [31:0]             reg_rdata,
   // receive fifo events, one per channel
   input  wire logic [NUM_CH-1:0]       rx_full_pkt,
   input  wire logic [NUM_CH-1:0]       rx_short_pkt,
   input  wire logic [NUM_CH-1:0]       rx_error,
   input  wire logic [NUM_CH-1:0]       rx_burst_done,
   // transmit fifo events and state
   input  wire logic [NUM_CH-1:0]       tx_space,
   input  wire logic [NUM_CH-1:0]       tx_fifo_full_pkt,
   input  wire logic [NUM_CH-1:0]       tx_burst_done,
   input  wire logic [NUM_CH-1:0]       tx_sent,
   // dma request lines
   output logic      [NUM_CH-1:0]       rx_dma_req,
   output logic      [NUM_CH-1:0]       tx_dma_req,
   // packet engine controls
   output logic      [NUM_CH-1:0]       tx_pkt_ready,
   output logic      [NUM_CH-1:0]       rx_pkt_release,
   output logic                         transceiver_powered,
   output logic                         controller_run,
   // interrupt
   output logic                         usb_irq
);
   localparam int SW = NUM_CH * ST_W;
   // channel select field of a length write, above the burst count
   localparam int LCH = 16;

   typedef struct packed {
      logic [7:0]              ctrl;
      logic [SW-1:0]           status;
      logic [SW-1:0]           mask;
      logic [NUM_CH*EP_W-1:0]  rx_ep;
      logic [NUM_CH*EP_W-1:0]  tx_ep;
      logic [NUM_CH*CNT_W-1:0] rx_left;
      logic [NUM_CH*CNT_W-1:0] tx_left;
      logic [31:0]             rdata;
      logic [NUM_CH-1:0]       arm;
      logic [NUM_CH-1:0]       rel;
      logic                    irq;
      logic                    pwr;
   } uedma_state_type;

   uedma_state_type r;
   uedma_state_type next_r;

   logic [NUM_CH-1:0] rx_ok;
   logic [NUM_CH-1:0] tx_ok;
   logic [NUM_CH-1:0] rx_cond;
   logic [NUM_CH-1:0] rx_req_w;
   logic [NUM_CH-1:0] tx_req_w;
   logic              run;

   // no operation while transceiver is down
   assign run = !r.ctrl[CTRL_PWRDN];

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         // endpoint zero is never serviced; the host bit does not pick the channel
         assign rx_ok[g] = run && r.ctrl[CTRL_RXEN]
            && (r.rx_ep[g*EP_W +: EP_W] != EP_CONTROL);
         assign tx_ok[g] = run && r.ctrl[CTRL_TXEN]
            && (r.tx_ep[g*EP_W +: EP_W] != EP_CONTROL);
         // per-packet mode asks only on full packets; the other mode
         // also drains a short last packet
         assign rx_cond[g] = rx_full_pkt[g]
            || (r.ctrl[CTRL_RXMODE] == per_transfer_request_mode
                && rx_short_pkt[g]);

         uedma_channel u_rx (
            .clock      (clock),
            .arst_n     (arst_n),
            .allowed    (rx_ok[g]),
            .cond       (rx_cond[g]),
            .burst_done (rx_burst_done[g]),
            .req        (rx_req_w[g])
         );
         // ask on space, drop after each burst until space falls or length is spent
         uedma_channel u_tx (
            .clock      (clock),
            .arst_n     (arst_n),
            .allowed    (tx_ok[g] && r.tx_left[g*CNT_W +: CNT_W] != '0),
            .cond       (tx_space[g]),
            .burst_done (tx_burst_done[g]),
            .req        (tx_req_w[g])
         );
      end
   endgenerate

   // registers, counters, events and the shared interrupt
   always_comb
   begin
      logic [SW-1:0] ev;
      logic [CNT_W-1:0] rl;
      logic [CNT_W-1:0] tl;
      ev = '0;
      rl = '0;
      tl = '0;
      next_r = r;
      next_r.rdata = 32'h0000_0000;
      next_r.arm = '0;
      next_r.rel = '0;
      for (int c = 0; c < NUM_CH; c++)
      begin
         rl = r.rx_left[c*CNT_W +: CNT_W];
         tl = r.tx_left[c*CNT_W +: CNT_W];
         if (rx_ok[c] && rx_burst_done[c] && rl != '0)
         begin
            rl = rl - CNT_W'(1);
            // per-transfer: interrupt only at end of transfer
            if (rl == '0 || (rx_short_pkt[c] &&
                r.ctrl[CTRL_RXMODE] == per_transfer_request_mode))
            begin
               rl = '0;
               ev[c*ST_W + ST_RXDONE] = 1'b1;
            end
            // release the drained packet without software
            next_r.rel[c] = r.ctrl[CTRL_RELEASE];
         end
         if (rx_ok[c] && rx_short_pkt[c]
             && r.ctrl[CTRL_RXMODE] == per_packet_request_mode)
            ev[c*ST_W + ST_RXSHRT] = 1'b1;
         if (rx_ok[c] && rx_error[c])
            ev[c*ST_W + ST_RXERR] = 1'b1;
         if (tx_ok[c] && tx_burst_done[c] && tl != '0)
         begin
            tl = tl - CNT_W'(1);
            // completion means fifo filled, not bus done
            if (tl == '0 ||
                r.ctrl[CTRL_TXMODE] == per_packet_request_mode)
               ev[c*ST_W + ST_TXDONE] = 1'b1;
         end
         if (tx_ok[c] && tx_sent[c])
            ev[c*ST_W + ST_TXPKT] = 1'b1;
         // arm a full packet with no software trigger
         next_r.arm[c] = run && r.ctrl[CTRL_ARM]
                         && tx_fifo_full_pkt[c];
         next_r.rx_left[c*CNT_W +: CNT_W] = rl;
         next_r.tx_left[c*CNT_W +: CNT_W] = tl;
      end
      // write: set wins over write-one-to-clear
      next_r.status = r.status & ~((reg_wr && reg_addr == REG_STATUS)
                       ? reg_wdata[SW-1:0] : '0);
      next_r.status = next_r.status | ev;
      if (reg_wr)
      begin
         case (reg_addr)
            REG_CTRL:  next_r.ctrl = reg_wdata[7:0];
            REG_MASK:  next_r.mask = reg_wdata[SW-1:0];
            REG_RXEP:  next_r.rx_ep = reg_wdata[NUM_CH*EP_W-1:0];
            REG_TXEP:  next_r.tx_ep = reg_wdata[NUM_CH*EP_W-1:0];
            REG_RXLEN: next_r.rx_left[reg_wdata[LCH+1:LCH]*CNT_W +: CNT_W] =
                          reg_wdata[CNT_W-1:0];
            REG_TXLEN: next_r.tx_left[reg_wdata[LCH+1:LCH]*CNT_W +: CNT_W] =
                          reg_wdata[CNT_W-1:0];
            default: ;
         endcase
      end
      // read data appear the next cycle only
      if (reg_rd)
      begin
         case (reg_addr)
            REG_CTRL:   next_r.rdata = {24'h000000, r.ctrl};
            REG_STATUS: next_r.rdata = 32'(r.status);
            REG_MASK:   next_r.rdata = 32'(r.mask);
            REG_RXEP:   next_r.rdata = 32'(r.rx_ep);
            REG_TXEP:   next_r.rdata = 32'(r.tx_ep);
            REG_STATE:  next_r.rdata = 32'({tx_req_w, rx_req_w});
            default:    next_r.rdata = 32'h0000_0000;
         endcase
      end
      // one line for every event, no source flag for dma
      next_r.irq = |(next_r.status & next_r.mask);
      // powered after reset; clearing powerdown restores it
      next_r.pwr = !next_r.ctrl[CTRL_PWRDN];
   end

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r      <= '0;
         r.ctrl <= CTRL_RESET;
         r.pwr  <= 1'b1;
      end
      else
         r <= next_r;
   end

   // outputs straight from flip-flops
   assign reg_rdata           = r.rdata;
   assign rx_dma_req          = rx_req_w;
   assign tx_dma_req          = tx_req_w;
   assign tx_pkt_ready        = r.arm;
   assign rx_pkt_release      = r.rel;
   assign transceiver_powered = r.pwr;
   assign controller_run      = r.pwr;
   assign usb_irq             = r.irq;
endmodule : uedma_top

`default_nettype wire

// ### testbench/uedma_props.sv
// uedma_props: port-level checks of the endpoint dma request logic
// assumes a bind onto uedma_top, one clock, async active-low reset
`default_nettype none

module uedma_props
   import uedma_pkg::*;
(
   // clock and reset
   input wire logic              clock,
   input wire logic              arst_n,
   // fifo side
   input wire logic [NUM_CH-1:0] rx_full_pkt,
   input wire logic [NUM_CH-1:0] rx_short_pkt,
   input wire logic [NUM_CH-1:0] rx_burst_done,
   input wire logic [NUM_CH-1:0] tx_space,
   input wire logic [NUM_CH-1:0] tx_fifo_full_pkt,
   input wire logic [NUM_CH-1:0] tx_burst_done,
   // outputs watched
   input wire logic [NUM_CH-1:0] rx_dma_req,
   input wire logic [NUM_CH-1:0] tx_dma_req,
   input wire logic [NUM_CH-1:0] tx_pkt_ready,
   input wire logic              transceiver_powered,
   input wire logic              controller_run
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   // a served burst, seen on channel a
   sequence s_rx_burst;
      rx_dma_req[0] && rx_burst_done[0];
   endsequence
   sequence s_tx_burst;
      tx_dma_req[0] && tx_burst_done[0];
   endsequence

   property p_rx_drop;
      s_rx_burst |=> !rx_dma_req[0];
   endproperty
   property p_tx_drop;
      s_tx_burst |=> !tx_dma_req[0];
   endproperty
   // request must hold until its burst is done while the controller runs
   property p_tx_hold;
      tx_dma_req[0] && !tx_burst_done[0] && controller_run |=> tx_dma_req[0];
   endproperty
   property p_rx_cond;
      $rose(rx_dma_req[0]) |-> $past(rx_full_pkt[0] | rx_short_pkt[0]);
   endproperty
   property p_tx_cond;
      $rose(tx_dma_req[0]) |-> $past(tx_space[0]);
   endproperty
   property p_arm;
      tx_pkt_ready[0] |-> $past(tx_fifo_full_pkt[0]);
   endproperty
   property p_run_pwr;
      !transceiver_powered |-> !controller_run ##1 (tx_pkt_ready == 3'h0);
   endproperty
   property p_run_req;
      !controller_run [*2] |-> rx_dma_req == 3'h0 && tx_dma_req == 3'h0;
   endproperty

   a_rx_drop: assert property (p_rx_drop)
      else $error("rx request held after burst");
   a_tx_drop: assert property (p_tx_drop)
      else $error("tx request held after burst");
   a_tx_hold: assert property (p_tx_hold)
      else $error("tx request dropped early");
   a_rx_cond: assert property (p_rx_cond)
      else $error("rx request without packet");
   a_tx_cond: assert property (p_tx_cond)
      else $error("tx request without space");
   a_arm: assert property (p_arm)
      else $error("packet armed without full fifo");
   a_run_pwr: assert property (p_run_pwr)
      else $error("running while powered down");
   a_run_req: assert property (p_run_req)
      else $error("request while stopped");
endmodule : uedma_props

bind uedma_top uedma_props i_props (.clock, .arst_n, .rx_full_pkt,
   .rx_short_pkt, .rx_burst_done, .tx_space, .tx_fifo_full_pkt,
   .tx_burst_done, .rx_dma_req, .tx_dma_req, .tx_pkt_ready,
   .transceiver_powered, .controller_run);

`default_nettype wire

// ### testbench/uedma_dma_model.sv
// uedma_dma_model: system dma controller serving request lines
// assumes one done pulse stands for a whole burst of byte items
`default_nettype none

module uedma_dma_model
   import uedma_pkg::*;
#(
   parameter int DELAY = 3
)
(
   // clock and reset
   input wire logic               clock,
   input wire logic               arst_n,
   // request in, burst done out
   input wire logic [NUM_CH-1:0]  req,
   output var logic [NUM_CH-1:0]  done
);
   logic [7:0]        cnt [NUM_CH];
   logic [NUM_CH-1:0] served;

   // whole burst per request, never single items; byte reads from a
   // fixed fifo address in 64-byte units, so one pulse per burst
   always_ff @(posedge clock or negedge arst_n)
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         if (!arst_n)
         begin
            cnt[c]    <= 8'h00;
            served[c] <= 1'h0;
            done[c]   <= 1'h0;
         end
         else
         begin
            done[c] <= 1'h0;
            if (!req[c])
            begin
               cnt[c]    <= 8'h00;
               served[c] <= 1'h0;
            end
            else if (!served[c] && cnt[c] == 8'(DELAY))
            begin
               done[c]   <= 1'h1;
               served[c] <= 1'h1;
            end
            else if (!served[c])
               cnt[c] <= cnt[c] + 8'h01;
         end
      end
   end
endmodule : uedma_dma_model

`default_nettype wire

// ### testbench/usb_endpoint_dma_request_logic_tb.sv
// usb_endpoint_dma_request_logic_tb: directed tests of uedma_top
// assumes two dma models as far side and the bound checker
`default_nettype none

module usb_endpoint_dma_request_logic_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import uedma_pkg::*;

   logic              clock = 1'h0;
   logic              arst_n = 1'h0;
   logic [AW-1:0]     reg_addr = '0;
   logic [31:0]       reg_wdata = '0;
   logic [31:0]       reg_rdata;
   logic              reg_wr = 1'h0;
   logic              reg_rd = 1'h0;
   logic [NUM_CH-1:0] rx_full_pkt = '0, rx_short_pkt = '0, rx_error = '0;
   logic [NUM_CH-1:0] tx_space = '0, tx_fifo_full_pkt = '0, tx_sent = '0;
   logic [NUM_CH-1:0] rx_burst_done, tx_burst_done, rx_dma_req, tx_dma_req;
   logic [NUM_CH-1:0] tx_pkt_ready, rx_pkt_release;
   logic              transceiver_powered, controller_run, usb_irq;
   logic              armed = 1'h0;
   int                failures = 0;
   int                num_checks = 0;

   uedma_top i_dut (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .rx_full_pkt, .rx_short_pkt, .rx_error,
      .rx_burst_done, .tx_space, .tx_fifo_full_pkt, .tx_burst_done,
      .tx_sent, .rx_dma_req, .tx_dma_req, .tx_pkt_ready, .rx_pkt_release,
      .transceiver_powered, .controller_run, .usb_irq);
   // prompt receive side, slow transmit side
   uedma_dma_model #(.DELAY(1)) i_rxdma (.clock, .arst_n,
      .req(rx_dma_req), .done(rx_burst_done));
   uedma_dma_model #(.DELAY(5)) i_txdma (.clock, .arst_n,
      .req(tx_dma_req), .done(tx_burst_done));

   always #10 clock = ~clock;
   // arm stays high only while tx_fifo_full_pkt is held, so latch it
   always @(posedge clock)
      if (tx_pkt_ready[0] === 1'h1)
         armed <= 1'h1;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_wr    <= 1'h1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'h0;
   endtask : wr

   task automatic rd(input logic [AW-1:0] a, input logic [31:0] e);
      @(posedge clock);
      reg_rd   <= 1'h1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'h0;
      #1 chk(reg_rdata, e);
   endtask : rd

   // bounded wait for the model's burst pulse on channel a
   task automatic wait_done(input bit tx);
      int i;
      for (i = 0; i < 30; i++)
      begin
         @(posedge clock);
         if ((tx ? tx_burst_done[0] : rx_burst_done[0]) === 1'h1)
            break;
      end
      chk(32'(i < 30), 32'h1);
   endtask : wait_done

   task automatic t_reset;
      chk(32'(transceiver_powered), 32'h1);
      chk(32'(controller_run), 32'h1);
      rd(REG_CTRL, 32'h0);
      rd(4'h8, 32'h0);
      $display("t_reset done");
   endtask : t_reset

   // two bursts, interrupt only when the whole transfer is over
   task automatic t_rx_transfer;
      wr(REG_MASK, 32'h7FFF);
      wr(REG_RXEP, 32'h1);
      wr(REG_RXLEN, 32'h2);
      wr(REG_CTRL, 32'h40);
      for (int k = 0; k < 2; k++)
      begin
         rx_full_pkt[0] <= 1'h1;
         wait_done(1'b0);
         rx_full_pkt[0] <= 1'h0;
         repeat (3) @(posedge clock);
         chk(32'(usb_irq), 32'(k));
      end
      rd(REG_STATUS, 32'h1);
      wr(REG_STATUS, 32'h1);
      rd(REG_STATUS, 32'h0);
      chk(32'(usb_irq), 32'h0);
      $display("t_rx_transfer done");
   endtask : t_rx_transfer

   // per-packet mode: short packet and error interrupt, no request
   task automatic t_short;
      wr(REG_RXLEN, 32'h2);
      wr(REG_CTRL, 32'h44);
      rx_short_pkt[0] <= 1'h1;
      rx_error[0]     <= 1'h1;
      @(posedge clock);
      rx_error[0] <= 1'h0;
      repeat (3) @(posedge clock);
      chk(32'(rx_dma_req[0]), 32'h0);
      rx_short_pkt[0] <= 1'h0;
      rd(REG_STATUS, 32'h6);
      wr(REG_STATUS, 32'h6);
      $display("t_short done");
   endtask : t_short

   // per-transfer: short last packet ends it; drained packet released
   task automatic t_release;
      wr(REG_RXEP, 32'h1);
      wr(REG_RXLEN, 32'h3);
      wr(REG_CTRL, 32'h60);
      rx_short_pkt[0] <= 1'h1;
      wait_done(1'b0);
      rx_short_pkt[0] <= 1'h0;
      @(posedge clock);
      chk(32'(rx_pkt_release[0]), 32'h1);
      rd(REG_STATUS, 32'h1);
      wr(REG_STATUS, 32'h1);
      $display("t_release done");
   endtask : t_release

   task automatic t_ep0;
      wr(REG_RXEP, 32'h0);
      wr(REG_CTRL, 32'h40);
      rx_full_pkt[0] <= 1'h1;
      repeat (4) @(posedge clock);
      chk(32'(rx_dma_req[0]), 32'h0);
      rx_full_pkt[0] <= 1'h0;
      $display("t_ep0 done");
   endtask : t_ep0

   // one burst of transmit, then length spent; auto arm on full fifo
   task automatic t_tx;
      wr(REG_TXEP, 32'h2);
      wr(REG_TXLEN, 32'h1);
      wr(REG_CTRL, 32'h90);
      tx_space[0] <= 1'h1;
      wait_done(1'b1);
      repeat (4) @(posedge clock);
      chk(32'(tx_dma_req[0]), 32'h0);
      tx_space[0]         <= 1'h0;
      tx_fifo_full_pkt[0] <= 1'h1;
      repeat (4) @(posedge clock);
      chk(32'(armed), 32'h1);
      tx_fifo_full_pkt[0] <= 1'h0;
      rd(REG_STATUS, 32'h08);
      @(posedge clock);
      tx_sent[0] <= 1'h1;
      @(posedge clock);
      tx_sent[0] <= 1'h0;
      rd(REG_STATUS, 32'h18);
      wr(REG_STATUS, 32'h18);
      $display("t_tx done");
   endtask : t_tx

   task automatic t_power;
      wr(REG_CTRL, 32'h12);
      repeat (2) @(posedge clock);
      chk(32'(transceiver_powered), 32'h0);
      chk(32'(controller_run), 32'h0);
      tx_fifo_full_pkt[0] <= 1'h1;
      repeat (2) @(posedge clock);
      chk(32'(tx_pkt_ready[0]), 32'h0);
      tx_fifo_full_pkt[0] <= 1'h0;
      wr(REG_CTRL, 32'h0);
      repeat (2) @(posedge clock);
      chk(32'(transceiver_powered), 32'h1);
      $display("t_power done");
   endtask : t_power

   task automatic conclude;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (2) @(posedge clock);
      arst_n <= 1'h1;
      t_reset();
      t_rx_transfer();
      t_short();
      t_release();
      t_ep0();
      t_tx();
      t_power();
      conclude();
   end

   // tests need about a hundred cycles; the 2000-cycle limit allows ample margin
   initial
   begin
      #40000;
      failures++;
      conclude();
   end
endmodule : usb_endpoint_dma_request_logic_tb

`default_nettype wire
